// ---- rtl/spectral_regs.sv ----
// Spectral result and misc configuration registers behind a two-wire serial slave
//
// Notes on behaviour
// [RULE1] Channel one result: low byte at 0x97, high byte at 0x98, read only.
// [RULE2] Channel two result: low byte at 0x99, high byte at 0x9A, read only.
// [RULE3] Channel three result: low 0x9B, high 0x9C, read only, zero by default.
// [RULE4] Channel four result: low 0x9D, high 0x9E, read only, zero by default.
// [RULE5] Channel five result: low 0x9F, high 0xA0, read only, zero by default.
// [RULE6] Low power idle bit enters low power when all functions wait or are off.
// [RULE7] Bank bit zero reaches 0x80 upward; one reaches 0x60 to 0x74; host matches it. Code maps only 0x60 to 0x6C of that window in bank one.
// [RULE8] Wait stretch bit multiplies the programmed wait interval by sixteen.
// [RULE9] Sleep on interrupt bit stops the oscillator while any interrupt is active.
// [RULE10] Oscillator stopped by an interrupt sets the sleeping status flag.
// [RULE11] Host restarts oscillator by clearing interrupts and the sleeping flag.
// [RULE12] Reading spectral status latches all result bytes from one measurement.
// [RULE13] With flicker detection on, channel five results read as zero.
// [RULE14] Sleeping flag is read only, resets to zero, sits at status bit 1. Code clears it when a one is written to that bit.
// [RULE15] Reserved config bits ignore writes, read defaults; fields reset to defaults.
// [RULE16] High byte forms result bits 15 to 8, low byte bits 7 to 0.
`timescale 1ns/1ns

`include "spectral_regs_cfg.svh"

module spectral_regs
  import spectral_regs_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = `DEVICE_ADDR_DEFAULT  // Arbitrary value
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  // Two-wire serial bus pins
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  output logic                  o_sda_out,
  output logic                  o_sda_oe,
  // Measurement side
  input  wire logic [4:0][15:0] i_chan_result,
  input  wire logic [7:0]       i_spectral_status,
  input  wire logic             i_flicker_enable,
  input  wire logic             i_all_idle,
  input  wire logic             i_irq_active,
  input  wire logic [15:0]      i_wait_interval,
  // Power and timing controls
  output logic                  o_low_power_idle,
  output logic                  o_osc_stop,
  output logic                  o_sleeping_due_to_irq,
  output logic                  o_bank_select,
  output logic                  o_wait_stretch,
  output logic [19:0]           o_wait_scaled
);

  // --------------------------------------------------------------------------
  // Reset image
  // --------------------------------------------------------------------------
  localparam logic [7:0] POWER_BANK_WAIT_CONFIG_RST = `POWER_BANK_WAIT_RESET;
  localparam logic [7:0] INTERRUPT_SLEEP_CONFIG_RST = `INT_SLEEP_CONFIG_RESET;

  localparam slice_state_type RESET_STATE = '{
    scl_s1:        1'b1,
    scl_s2:        1'b1,
    scl_s3:        1'b1,
    sda_s1:        1'b1,
    sda_s2:        1'b1,
    sda_s3:        1'b1,
    state:         ST_IDLE,
    bit_cnt:       4'h0,
    shift:         8'h00,
    ptr:           8'h00,
    rw:            1'b0,
    ack_seen:      1'b0,
    sda_oe:        1'b0,
    low_power:     POWER_BANK_WAIT_CONFIG_RST[`LOW_POWER_BIT],
    bank_select:   POWER_BANK_WAIT_CONFIG_RST[`BANK_SELECT_BIT],
    wait_stretch:  POWER_BANK_WAIT_CONFIG_RST[`WAIT_STRETCH_BIT],
    sleep_on_irq:  INTERRUPT_SLEEP_CONFIG_RST[`SLEEP_ON_IRQ_BIT],
    sleeping:      1'b0,
    latched:       '0,
    low_power_out: 1'b0,
    osc_stop:      1'b0,
    wait_scaled:   20'h00000
  };

  // --------------------------------------------------------------------------
  // Address and read decode
  // --------------------------------------------------------------------------

  // Folds the bank-1 alias window onto the canonical map; the power, bank and wait register
  // stays reachable in both banks so the host can never lock itself out of the bank bit
  function automatic logic [7:0] map_addr(input logic [7:0] a, input logic bank);
    logic [7:0] off;
    off = a - `BANK1_LOW_ADDR;
    if (a == `POWER_BANK_WAIT_ADDR) begin
      return a;
    end
    if (bank) begin  // [RULE7]
      if (a >= `BANK1_LOW_ADDR && a <= `BANK1_HIGH_ADDR && off <= `BANK1_ALIAS_SPAN) begin
        return `SPECTRAL_STATUS_ADDR + off;
      end
      return `UNMAPPED_ADDR;
    end
    if (a >= `BANK0_LOW_ADDR) begin  // [RULE7]
      return a;
    end
    return `UNMAPPED_ADDR;
  endfunction

  // Byte seen by the host at a canonical address
  function automatic logic [7:0] read_value(input logic [7:0]      canon,
                                            input slice_state_type s,
                                            input logic [7:0]      status);
    logic [7:0] idx;
    logic [7:0] v;
    idx = canon - `CHAN1_RESULT_LOW_ADDR;
    v   = 8'h00;
    if (canon >= `CHAN1_RESULT_LOW_ADDR && canon <= `CHAN5_RESULT_HIGH_ADDR) begin
      // Odd index is the high byte of the pair  [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
      v = idx[0] ? s.latched[idx[3:1]][15:8] : s.latched[idx[3:1]][7:0];  // [RULE16]
    end else if (canon == `SPECTRAL_STATUS_ADDR) begin
      v = status;
    end else if (canon == `SLEEP_STATUS_ADDR) begin
      v[`SLEEPING_IRQ_BIT] = s.sleeping;  // [RULE14]
    end else if (canon == `POWER_BANK_WAIT_ADDR) begin
      v[`LOW_POWER_BIT]    = s.low_power;  // [RULE15]
      v[`BANK_SELECT_BIT]  = s.bank_select;
      v[`WAIT_STRETCH_BIT] = s.wait_stretch;
    end else if (canon == `INT_SLEEP_CONFIG_ADDR) begin
      v = `INT_SLEEP_RESERVED;  // [RULE15]
      v[`SLEEP_ON_IRQ_BIT] = s.sleep_on_irq;
    end
    return v;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  slice_state_type cur;
  slice_state_type next_cur;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Edges are taken from the second and third stages, never the first
  assign scl_rise  = cur.scl_s2 & ~cur.scl_s3;
  assign scl_fall  = ~cur.scl_s2 & cur.scl_s3;
  assign bus_start = cur.scl_s2 & cur.scl_s3 & cur.sda_s3 & ~cur.sda_s2;
  assign bus_stop  = cur.scl_s2 & cur.scl_s3 & ~cur.sda_s3 & cur.sda_s2;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    logic [7:0] canon;
    logic [7:0] rbyte;
    logic       clear_sleep;
    canon       = map_addr(cur.ptr, cur.bank_select);
    rbyte       = read_value(canon, cur, i_spectral_status);
    clear_sleep = 1'b0;
    next_cur    = cur;

    // Pin synchronisers
    next_cur.scl_s1 = i_scl;
    next_cur.scl_s2 = cur.scl_s1;
    next_cur.scl_s3 = cur.scl_s2;
    next_cur.sda_s1 = i_sda;
    next_cur.sda_s2 = cur.sda_s1;
    next_cur.sda_s3 = cur.sda_s2;

    if (bus_start) begin
      // Start or repeated start restarts the address phase
      next_cur.state   = ST_ADDR;
      next_cur.bit_cnt = 4'h0;
      next_cur.sda_oe  = 1'b0;
    end else if (bus_stop) begin
      next_cur.state  = ST_IDLE;
      next_cur.sda_oe = 1'b0;
    end else begin
      unique case (cur.state)
        ST_IDLE: begin
          next_cur.sda_oe = 1'b0;
        end
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise) begin
            next_cur.shift   = {cur.shift[6:0], cur.sda_s2};
            next_cur.bit_cnt = cur.bit_cnt + 4'h1;
          end else if (scl_fall && cur.bit_cnt == `BIT_COUNT_FULL) begin
            next_cur.bit_cnt = 4'h0;
            if (cur.state == ST_ADDR) begin
              if (cur.shift[7:1] == DEVICE_ADDR) begin
                next_cur.rw     = cur.shift[0];
                next_cur.sda_oe = 1'b1;
                next_cur.state  = ST_ADDR_ACK;
              end else begin
                next_cur.state = ST_IDLE;  // Not ours: stay off the bus
              end
            end else if (cur.state == ST_REG) begin
              next_cur.ptr    = cur.shift;
              next_cur.sda_oe = 1'b1;
              next_cur.state  = ST_REG_ACK;
            end else begin
              // Register write, then step to the next address
              if (canon == `POWER_BANK_WAIT_ADDR) begin
                next_cur.low_power    = cur.shift[`LOW_POWER_BIT];  // [RULE6]
                next_cur.bank_select  = cur.shift[`BANK_SELECT_BIT];  // [RULE7]
                next_cur.wait_stretch = cur.shift[`WAIT_STRETCH_BIT];  // [RULE8]
              end else if (canon == `INT_SLEEP_CONFIG_ADDR) begin
                next_cur.sleep_on_irq = cur.shift[`SLEEP_ON_IRQ_BIT];  // [RULE9]
              end else if (canon == `SLEEP_STATUS_ADDR) begin
                clear_sleep = cur.shift[`SLEEPING_IRQ_BIT];  // [RULE11]
              end
              next_cur.ptr    = cur.ptr + 8'h01;
              next_cur.sda_oe = 1'b1;
              next_cur.state  = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            next_cur.sda_oe  = 1'b0;
            next_cur.bit_cnt = 4'h0;
            if (cur.state == ST_ADDR_ACK && cur.rw) begin
              next_cur.shift  = rbyte;
              next_cur.sda_oe = ~rbyte[7];
              next_cur.ptr    = cur.ptr + 8'h01;
              next_cur.state  = ST_RDATA;
            end else if (cur.state == ST_ADDR_ACK) begin
              next_cur.state = ST_REG;
            end else begin
              next_cur.state = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            next_cur.bit_cnt = cur.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (cur.bit_cnt == `BIT_COUNT_FULL) begin
              next_cur.sda_oe  = 1'b0;  // Release for the host's acknowledge
              next_cur.bit_cnt = 4'h0;
              next_cur.state   = ST_RACK;
            end else begin
              next_cur.shift  = {cur.shift[6:0], 1'b0};
              next_cur.sda_oe = ~cur.shift[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            next_cur.ack_seen = ~cur.sda_s2;
          end else if (scl_fall) begin
            if (cur.ack_seen) begin
              next_cur.shift  = rbyte;
              next_cur.sda_oe = ~rbyte[7];
              next_cur.ptr    = cur.ptr + 8'h01;
              next_cur.state  = ST_RDATA;
            end else begin
              next_cur.state = ST_IDLE;  // Host ended the read with a not-acknowledge
            end
          end
        end
        default: begin
          next_cur.state  = ST_IDLE;
          next_cur.sda_oe = 1'b0;
        end
      endcase
    end

    // Status fetch snapshots every result so a burst read is coherent
    if (!bus_start && !bus_stop && scl_fall && cur.rw &&
        ((cur.state == ST_ADDR_ACK) || (cur.state == ST_RACK && cur.ack_seen)) &&
        canon == `SPECTRAL_STATUS_ADDR) begin
      next_cur.latched = i_chan_result;  // [RULE12]
      if (i_flicker_enable) begin
        next_cur.latched[4] = 16'h0000;  // [RULE13]
      end
    end

    // Interrupt sleep: set wins over a clear in the same cycle
    if (cur.sleep_on_irq && i_irq_active) begin
      next_cur.sleeping = 1'b1;  // [RULE10]
    end else if (clear_sleep) begin
      next_cur.sleeping = 1'b0;  // [RULE11]
    end

    // Power and timing outputs
    next_cur.low_power_out = cur.low_power & i_all_idle;  // [RULE6]
    next_cur.osc_stop      = next_cur.sleeping;  // [RULE9]
    next_cur.wait_scaled   = cur.wait_stretch ?
                             {i_wait_interval, 4'h0} :  // [RULE8]
                             {4'h0, i_wait_interval};
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cur <= RESET_STATE;  // [RULE15] [RULE14]
    end else begin
      cur <= next_cur;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Open drain: only ever pulls low
  assign o_sda_out             = 1'b0;
  assign o_sda_oe              = cur.sda_oe;
  assign o_low_power_idle      = cur.low_power_out;
  assign o_osc_stop            = cur.osc_stop;
  assign o_sleeping_due_to_irq = cur.sleeping;
  assign o_bank_select         = cur.bank_select;
  assign o_wait_stretch        = cur.wait_stretch;
  assign o_wait_scaled         = cur.wait_scaled;

endmodule  // spectral_regs

// ---- rtl/spectral_regs_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the spectral register slice
`ifndef SPECTRAL_REGS_CFG_SVH
`define SPECTRAL_REGS_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SPECTRAL_STATUS_ADDR   8'h94
`define CHAN1_RESULT_LOW_ADDR  8'h97
`define CHAN1_RESULT_HIGH_ADDR 8'h98
`define CHAN2_RESULT_LOW_ADDR  8'h99
`define CHAN2_RESULT_HIGH_ADDR 8'h9A
`define CHAN3_RESULT_LOW_ADDR  8'h9B
`define CHAN3_RESULT_HIGH_ADDR 8'h9C
`define CHAN4_RESULT_LOW_ADDR  8'h9D
`define CHAN4_RESULT_HIGH_ADDR 8'h9E
`define CHAN5_RESULT_LOW_ADDR  8'h9F
`define CHAN5_RESULT_HIGH_ADDR 8'hA0
`define SLEEP_STATUS_ADDR      8'hA3
`define POWER_BANK_WAIT_ADDR   8'hA9
`define INT_SLEEP_CONFIG_ADDR  8'hAC
`define UNMAPPED_ADDR          8'h00

// ----------------------------------------------------------------------------
// Bank windows
// ----------------------------------------------------------------------------
`define BANK0_LOW_ADDR         8'h80
`define BANK1_LOW_ADDR         8'h60
`define BANK1_HIGH_ADDR        8'h74
`define BANK1_ALIAS_SPAN       8'h0C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LOW_POWER_BIT          5
`define BANK_SELECT_BIT        4
`define WAIT_STRETCH_BIT       2
`define SLEEP_ON_IRQ_BIT       4
`define SLEEPING_IRQ_BIT       1
`define WAIT_STRETCH_SHIFT     4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define POWER_BANK_WAIT_RESET  8'h00
`define INT_SLEEP_CONFIG_RESET 8'h0C
`define INT_SLEEP_RESERVED     8'h0C
`define DEVICE_ADDR_DEFAULT    7'h2A
`define BIT_COUNT_FULL         4'h8

`endif

// ---- rtl/spectral_regs_pkg.sv ----
// Types shared by the spectral result and configuration register slice
package spectral_regs_pkg;

  // Serial slave states, Gray coded along the usual path
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_REG       = 4'h2,
    ST_REG_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RACK      = 4'hC
  } slave_state_type;

  // Whole state of the register slice
  typedef struct packed {
    logic                 scl_s1;
    logic                 scl_s2;
    logic                 scl_s3;
    logic                 sda_s1;
    logic                 sda_s2;
    logic                 sda_s3;
    slave_state_type      state;
    logic [3:0]           bit_cnt;
    logic [7:0]           shift;
    logic [7:0]           ptr;
    logic                 rw;
    logic                 ack_seen;
    logic                 sda_oe;
    logic                 low_power;
    logic                 bank_select;
    logic                 wait_stretch;
    logic                 sleep_on_irq;
    logic                 sleeping;
    logic [4:0][15:0]     latched;
    logic                 low_power_out;
    logic                 osc_stop;
    logic [19:0]          wait_scaled;
  } slice_state_type;

endpackage

// ---- verif/spectral_regs_sva.sv ----
// Port-level assertions for the spectral register slice
`timescale 1ns/1ns

module spectral_regs_sva (
  // Clock, reset and pin stimulus
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_scl,
  input wire logic        i_all_idle,
  input wire logic        i_irq_active,
  input wire logic [15:0] i_wait_interval,
  // Outputs under watch
  input wire logic        o_sda_oe,
  input wire logic        o_low_power_idle,
  input wire logic        o_osc_stop,
  input wire logic        o_sleeping_due_to_irq,
  input wire logic        o_bank_select,
  input wire logic        o_wait_stretch,
  input wire logic [19:0] o_wait_scaled
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  // First edge after reset, and idle going away while low power is on
  sequence rst_release;
    $fell(i_sys_rst);
  endsequence
  sequence idle_drop;
    o_low_power_idle ##0 !i_all_idle;
  endsequence

  a_reset_clear:
    assert property (rst_release |-> !o_sleeping_due_to_irq && !o_bank_select
                     && !o_wait_stretch && o_wait_scaled == 20'h00000)
      else $error("outputs not at defaults after reset");
  a_lp_cause:
    assert property (o_low_power_idle |-> $past(i_all_idle))
      else $error("low power without idle functions");
  a_lp_drop:
    assert property (idle_drop |=> !o_low_power_idle)
      else $error("low power kept after activity");
  // Stretch compared only while it is steady, so a write edge is not judged
  a_scale_track:
    assert property (!i_sys_rst ##1 $stable(o_wait_stretch) |-> o_wait_scaled ==
                     (o_wait_stretch ? {$past(i_wait_interval), 4'h0}
                                     : {4'h0, $past(i_wait_interval)}))
      else $error("scaled wait interval wrong");
  a_osc_flag:
    assert property (o_osc_stop == o_sleeping_due_to_irq)
      else $error("oscillator stop and sleeping flag differ");
  a_sleep_cause:
    assert property ($rose(o_sleeping_due_to_irq) |-> $past(i_irq_active))
      else $error("sleeping flag set without interrupt");
  a_sleep_clear:
    assert property ($fell(o_sleeping_due_to_irq) |-> !$past(i_scl, 2))
      else $error("sleeping flag cleared outside a bus write");
  a_cfg_by_bus:
    assert property ($changed({o_bank_select, o_wait_stretch}) |-> !$past(i_scl, 2))
      else $error("config bit moved outside a bus write");
  a_oe_scl_low:
    assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
      else $error("data line changed while clock high");
endmodule // spectral_regs_sva

bind spectral_regs spectral_regs_sva u_sva (.i_core_clk, .i_sys_rst, .i_scl, .i_all_idle,
  .i_irq_active, .i_wait_interval, .o_sda_oe, .o_low_power_idle, .o_osc_stop,
  .o_sleeping_due_to_irq, .o_bank_select, .o_wait_stretch, .o_wait_scaled);

// ---- verif/serial_host_model.sv ----
// Host on the two-wire bus: open-drain master with register read and write tasks
`timescale 1ns/1ns

module serial_host_model #(
  parameter logic [6:0] TARGET = 7'h2A  // Arbitrary bus address
) (
  // Clock and wire level
  input  wire logic       i_core_clk,
  input  wire logic       i_sda,
  // Open-drain drives, 1 means released
  output logic            o_scl,
  output logic            o_sda,
  // One-cycle strobe per byte read
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_data
);
  // ---------------------------------------------------------------------------
  // Bit and frame tasks
  // ---------------------------------------------------------------------------
  logic n0, n1, n2;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_rd_valid = 1'b0;
    o_rd_data = 8'h00;
  end

  // Quarter bit of four clocks keeps the low phase at eight, above the six needed
  task automatic step(input logic c, input logic d);
    repeat (4) @(negedge i_core_clk);
    o_scl = c;
    o_sda = d;
  endtask
  task automatic xbit(input logic b, output logic r);
    step(1'b0, b);
    step(1'b1, b);
    step(1'b1, b);
    r = i_sda;
    step(1'b0, b);
  endtask
  task automatic start();
    step(o_scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic send(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) xbit(b[i], n2);
    xbit(1'b1, nak);
  endtask
  task automatic recv(input logic last);
    for (int i = 7; i >= 0; i--) xbit(1'b1, o_rd_data[i]);
    o_rd_valid = 1'b1;
    @(negedge i_core_clk);
    o_rd_valid = 1'b0;
    xbit(last, n2);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                    output logic nak);
    start();
    send({dev, 1'b0}, n0);
    send(ra, n1);
    send(d, nak);
    stop();
    nak = nak | n0 | n1;
  endtask
  // Register pointer set by a write phase, then a repeated start for the data
  task automatic rd(input logic [7:0] ra, input int n);
    start();
    send({TARGET, 1'b0}, n0);
    send(ra, n1);
    start();
    send({TARGET, 1'b1}, n0);
    for (int k = 1; k <= n; k++) recv(k == n);
    stop();
  endtask
endmodule // serial_host_model

// ---- verif/tb.sv ----
// Self-checking bench for the spectral result and configuration register slice
`timescale 1ns/1ns

module tb;
  // ---------------------------------------------------------------------------
  // Signals, design and host
  // ---------------------------------------------------------------------------
  localparam logic [6:0] DEV = 7'h2A;  // Arbitrary bus address
  logic             clk, rst, flick, idle, irq, scl, host_sda, sda_oe, nak, rd_valid;
  logic             lp, osc, slp, bank, strch;
  logic [4:0][15:0] chan, snap;
  logic [7:0]       stat, rd_data, exp_v;
  logic [15:0]      wint;
  logic [19:0]      wscaled;
  logic [7:0]       exp_q[$];
  int               err_total, cmp_count;
  wire logic        sda_wire = host_sda & ~sda_oe;  // Pull-up: released line reads high

  spectral_regs #(.DEVICE_ADDR(DEV)) dut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda_wire),
    .o_sda_out(), .o_sda_oe(sda_oe), .i_chan_result(chan), .i_spectral_status(stat),
    .i_flicker_enable(flick), .i_all_idle(idle), .i_irq_active(irq),
    .i_wait_interval(wint), .o_low_power_idle(lp), .o_osc_stop(osc),
    .o_sleeping_due_to_irq(slp), .o_bank_select(bank), .o_wait_stretch(strch),
    .o_wait_scaled(wscaled));
  serial_host_model #(.TARGET(DEV)) host (.i_core_clk(clk), .i_sda(sda_wire),
    .o_scl(scl), .o_sda(host_sda), .o_rd_valid(rd_valid), .o_rd_data(rd_data));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // Checking tasks and read monitor
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic rd_one(input logic [7:0] ra, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(ra, 1);
  endtask
  task automatic push_res(input logic [4:0][15:0] c);
    for (int k = 0; k < 10; k++) exp_q.push_back(k[0] ? c[k>>1][15:8] : c[k>>1][7:0]);
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    host.wr(DEV, ra, d, nak);
    chk(20'(nak), 20'h00000);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Oldest note is matched against each byte the host reads back
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      chk({12'h000, rd_data}, {12'h000, exp_v});
    end
  end

  // About 20k clocks are needed; three times that still stays under the cap
  initial begin
    #8000000;
    err_total++;
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    err_total = 0;
    cmp_count = 0;
    void'($urandom(37));
    rst = 1'b1;
    {flick, idle, irq} = 3'h0;
    chan = '0;
    stat = 8'($urandom);
    wint = 16'($urandom);
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rd_one(8'hA9, 8'h00);
    rd_one(8'hAC, 8'h0C);
    rd_one(8'hA3, 8'h00);
    push_res(chan);
    host.rd(8'h97, 10);
    done("defaults");
    // Live results move after the status read; the held copy must not
    chan = 80'({$urandom, $urandom, $urandom});
    snap = chan;
    rd_one(8'h94, stat);
    chan = ~chan;
    push_res(snap);
    host.rd(8'h97, 10);
    host.wr(DEV, 8'h9F, 8'hFF, nak);
    exp_q.push_back(snap[4][7:0]);
    exp_q.push_back(snap[4][15:8]);
    host.rd(8'h9F, 2);
    rd_one(8'h94, stat);
    push_res(chan);
    host.rd(8'h97, 10);
    done("snapshot");
    flick = 1'b1;
    snap = chan;
    snap[4] = 16'h0000;
    rd_one(8'h94, stat);
    push_res(snap);
    host.rd(8'h97, 10);
    flick = 1'b0;
    done("flicker");
    // Config bits set, reserved bits must stay at their defaults
    wr(8'hA9, 8'hFF);
    rd_one(8'hA9, 8'h34);
    chk(20'(bank), 20'h00001);
    chk(20'(strch), 20'h00001);
    chk(wscaled, {wint, 4'h0});
    idle = 1'b1;
    repeat (3) @(negedge clk);
    chk(20'(lp), 20'h00001);
    idle = 1'b0;
    repeat (3) @(negedge clk);
    chk(20'(lp), 20'h00000);
    snap = chan;
    rd_one(8'h60, stat);
    exp_q.push_back(snap[0][7:0]);
    exp_q.push_back(snap[0][15:8]);
    host.rd(8'h63, 2);
    rd_one(8'h70, 8'h00);
    wr(8'hA9, 8'h00);
    chk({19'h00000, bank}, 20'h00000);
    chk(20'(strch), 20'h00000);
    chk(wscaled, {4'h0, wint});
    rd_one(8'h00, 8'h00);
    done("config");
    wr(8'hAC, 8'hFF);
    rd_one(8'hAC, 8'h1C);
    irq = 1'b1;
    repeat (3) @(negedge clk);
    chk({osc, slp}, 20'h00003);
    rd_one(8'hA3, 8'h02);
    wr(8'hA3, 8'h02);
    chk(20'(slp), 20'h00001);
    irq = 1'b0;
    wr(8'hA3, 8'h02);
    chk({osc, slp}, 20'h00000);
    wr(8'hAC, 8'h00);
    irq = 1'b1;
    repeat (3) @(negedge clk);
    chk({osc, slp}, 20'h00000);
    irq = 1'b0;
    done("sleep");
    host.wr(DEV ^ 7'h01, 8'hA9, 8'hFF, nak);
    chk({nak, bank}, 20'h00002);
    done("foreign address");
    end_of_test();
  end
endmodule // tb
